/* File: vcip_pkg.sv */
// package: constants, states and carriers of the video capture input port
package vcip_pkg;
    // core clock rate and decoder control bit rate
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int I2C_SCL_HZ = 100_000;
    // quarter of a serial clock period; rounded up so the bit rate never exceeds the target
    localparam int I2C_QTR_CYCLES = (SYS_CLK_HZ + 4 * I2C_SCL_HZ - 1) / (4 * I2C_SCL_HZ);
    localparam int QCNT_W = 6;
    localparam logic [QCNT_W-1:0] QCNT_MAX = QCNT_W'(I2C_QTR_CYCLES - 1);
    localparam logic [QCNT_W-1:0] QCNT_RST = 6'h00;
    // pixel bus width and field positions
    localparam int PIX_W = 16;
    localparam int LANE_W = 8;
    localparam int RED_LSB = 11;
    localparam int GREEN_LSB = 5;
    localparam int BLUE_LSB = 0;
    localparam int LUMA_LSB = 8;
    localparam int CHROMA_LSB = 0;
    // decoder control transfer framing
    localparam logic I2C_RW_WRITE = 1'b0;
    localparam logic [2:0] BIT_TOP = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h0;
    localparam logic [1:0] BYTE_FIRST = 2'h0;
    localparam logic [1:0] BYTE_LAST = 2'h2;
    localparam logic [1:0] PHASE_RST = 2'h0;
    localparam logic SCL_IDLE = 1'b1;
    // controller states
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_START,
        I2C_DATA,
        I2C_ACK,
        I2C_STOP
    } vcip_i2c_state_t;
    // one decoder register write
    typedef struct packed {
        logic [6:0] dev_addr;
        logic [7:0] reg_addr;
        logic [7:0] data;
    } vcip_i2c_cmd_t;
    // one captured pixel with its framing
    typedef struct packed {
        logic [4:0] red;
        logic [5:0] green;
        logic [4:0] blue;
        logic [7:0] luma;
        logic [7:0] chroma;
        logic chroma_v;
        logic line_start;
        logic field_start;
        logic field_odd;
    } vcip_pixel_t;
endpackage : vcip_pkg

/* File: vcip_capture_port.sv */
// module: video capture input port with decoder control master
`timescale 1ns/1ps
`default_nettype none
module vcip_capture_port (
    input wire logic core_clk_i, // core clock, 20 MHz
    input wire logic rst_i, // synchronous reset, active high
    input wire logic pixel_clock_in_i, // decoder pixel clock
    input wire logic [vcip_pkg::PIX_W-1:0] video_pixel_bus_i, // pixel bus
    input wire logic horizontal_reference_in_i, // line sync
    input wire logic vertical_sync_in_i, // field sync
    input wire logic mode_yuv_i, // 1 yuv 4:2:2, 0 rgb 5:6:5
    input wire logic mode_8bit_i, // 1 low lane only
    output var vcip_pkg::vcip_pixel_t pixel_o, // pixel, pixel clock domain
    output logic pixel_valid_o, // pixel valid, pixel clock domain
    output logic field_start_o, // field start pulse, core domain
    output logic line_start_o, // line start pulse, core domain
    output logic field_odd_o, // current field odd, core domain
    input wire logic i2c_start_i, // start a register write
    input wire vcip_pkg::vcip_i2c_cmd_t i2c_cmd_i, // write contents
    output logic i2c_busy_o, // transfer in progress
    output logic i2c_done_o, // transfer finished pulse
    output logic i2c_nack_o, // last transfer not acknowledged
    output logic decoder_ctrl_scl_o, // serial clock out
    input wire logic decoder_ctrl_sda_i, // serial data in
    output logic decoder_ctrl_sda_o, // serial data out level
    output logic decoder_ctrl_sda_oe_o // serial data drive enable
);
    // ---------------- pixel clock domain ----------------
    logic prst_meta; // reset sync stage one
    logic prst; // reset in pixel domain
    logic [1:0] pmode_meta; // mode sync stage one
    logic [1:0] pmode; // {yuv, 8bit} in pixel domain
    logic [vcip_pkg::PIX_W-1:0] bus_meta; // pin stage one
    logic [vcip_pkg::PIX_W-1:0] bus_smp; // pin stage two
    logic h_meta, h_smp; // reference pin stages one and two
    logic v_meta, v_smp; // sync pin stages one and two
    logic h_prev; // previous reference sample
    logic v_prev; // previous sync sample
    logic chroma_v; // chroma of last pixel was v
    logic field_odd; // odd field flag
    logic seen_field; // a field edge has been seen
    logic field_tog; // flips on each field start
    logic line_tog; // flips on each line start
    vcip_pkg::vcip_pixel_t pix; // registered pixel
    logic next_h_prev, next_v_prev, next_chroma_v, next_field_odd; // next pixel flags
    logic next_seen_field, next_field_tog, next_line_tog; // next event state
    vcip_pkg::vcip_pixel_t next_pix;
    logic h_edge; // reference changed between samples
    logic v_edge; // sync changed between samples
    logic [vcip_pkg::PIX_W-1:0] lane; // bus after width select

    // input stages; two flops keep the pins away from logic
    always_ff @(posedge pixel_clock_in_i) begin
        prst_meta <= rst_i;
        prst <= prst_meta;
        pmode_meta <= {mode_yuv_i, mode_8bit_i};
        pmode <= pmode_meta;
        bus_meta <= video_pixel_bus_i;
        bus_smp <= bus_meta;
        h_meta <= horizontal_reference_in_i;
        h_smp <= h_meta;
        v_meta <= vertical_sync_in_i;
        v_smp <= v_meta;
    end

    // pixel decode and framing
    always_comb begin
        h_edge = h_smp ^ h_prev;
        v_edge = v_smp ^ v_prev;
        // upper lines ignored in narrow mode
        lane = pmode[0] ? {8'h00, bus_smp[vcip_pkg::LANE_W-1:0]} : bus_smp;
        next_h_prev = h_smp;
        next_v_prev = v_smp;
        next_field_odd = field_odd;
        next_seen_field = seen_field | v_edge;
        next_field_tog = field_tog ^ v_edge;
        next_line_tog = line_tog ^ h_edge;
        if (v_edge) begin
            next_field_odd = h_smp;
        end
        // chroma restarts with u at each line
        if (h_edge || v_edge) begin
            next_chroma_v = 1'b0;
        end else begin
            next_chroma_v = ~chroma_v;
        end
        next_pix.red = lane[vcip_pkg::RED_LSB +: 5];
        next_pix.green = lane[vcip_pkg::GREEN_LSB +: 6];
        next_pix.blue = lane[vcip_pkg::BLUE_LSB +: 5];
        next_pix.luma = lane[vcip_pkg::LUMA_LSB +: 8];
        next_pix.chroma = lane[vcip_pkg::CHROMA_LSB +: 8];
        next_pix.chroma_v = pmode[1] & next_chroma_v;
        next_pix.line_start = h_edge;
        next_pix.field_start = v_edge;
        next_pix.field_odd = next_field_odd;
        // rgb mode carries no chroma, yuv mode no colour planes
        if (pmode[1]) begin
            next_pix.red = 5'h00;
            next_pix.green = 6'h00;
            next_pix.blue = 5'h00;
        end else begin
            next_pix.luma = 8'h00;
            next_pix.chroma = 8'h00;
        end
        if (prst) begin
            next_chroma_v = 1'b1;
            next_field_odd = 1'b0;
            next_seen_field = 1'b0;
            next_field_tog = 1'b0;
            next_line_tog = 1'b0;
            next_pix = '0;
        end
    end

    // pixel state registers
    always_ff @(posedge pixel_clock_in_i) begin
        h_prev <= next_h_prev;
        v_prev <= next_v_prev;
        chroma_v <= next_chroma_v;
        field_odd <= next_field_odd;
        seen_field <= next_seen_field;
        field_tog <= next_field_tog;
        line_tog <= next_line_tog;
        pix <= next_pix;
    end

    // valid only once the first field has begun
    assign pixel_o = pix;
    assign pixel_valid_o = seen_field;

    // ---------------- core clock domain ----------------
    logic ftog_meta, ftog_sync, ftog_hist; // field toggle sync stages and history
    logic ltog_meta, ltog_sync, ltog_hist; // line toggle sync stages and history
    logic odd_meta, odd_sync; // odd flag sync stages
    logic sda_meta, sda_sync; // data pin sync stages
    logic fstart, lstart; // registered field and line pulses

    // crossings; events travel as toggles, the odd flag as a level
    always_ff @(posedge core_clk_i) begin
        ftog_meta <= field_tog;
        ftog_sync <= ftog_meta;
        ltog_meta <= line_tog;
        ltog_sync <= ltog_meta;
        odd_meta <= field_odd;
        odd_sync <= odd_meta;
        sda_meta <= decoder_ctrl_sda_i;
        sda_sync <= sda_meta;
        if (rst_i) begin
            ftog_hist <= 1'b0;
            ltog_hist <= 1'b0;
            fstart <= 1'b0;
            lstart <= 1'b0;
        end else begin
            ftog_hist <= ftog_sync;
            ltog_hist <= ltog_sync;
            fstart <= ftog_sync ^ ftog_hist;
            lstart <= ltog_sync ^ ltog_hist;
        end
    end

    assign field_start_o = fstart;
    assign line_start_o = lstart;
    assign field_odd_o = odd_sync;

    // ---------------- decoder control master ----------------
    vcip_pkg::vcip_i2c_state_t state; // controller state
    logic [1:0] phase; // quarter within a bit
    logic [vcip_pkg::QCNT_W-1:0] qcnt; // cycles within a quarter
    logic [2:0] bitn; // bit being sent
    logic [1:0] byten; // byte being sent
    logic [7:0] shreg; // byte shifted out
    logic scl; // serial clock level
    logic sda_low; // pulling data low
    logic nack; // missing acknowledge
    logic done; // finish pulse
    vcip_pkg::vcip_i2c_cmd_t cmd; // latched command
    vcip_pkg::vcip_i2c_state_t next_state;
    logic [1:0] next_phase;
    logic [vcip_pkg::QCNT_W-1:0] next_qcnt;
    logic [2:0] next_bitn;
    logic [1:0] next_byten;
    logic [7:0] next_shreg;
    logic next_scl, next_sda_low, next_nack, next_done; // next line levels and flags
    vcip_pkg::vcip_i2c_cmd_t next_cmd;
    logic [7:0] load_byte; // byte after the current one

    // byte order: device address with write, register, data
    always_comb begin
        unique case (byten)
            2'h0: load_byte = cmd.reg_addr;
            2'h1: load_byte = cmd.data;
            default: load_byte = cmd.data;
        endcase
    end

    // bit sequencer; one quarter of the serial clock per phase
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_qcnt = qcnt;
        next_bitn = bitn;
        next_byten = byten;
        next_shreg = shreg;
        next_scl = scl;
        next_sda_low = sda_low;
        next_nack = nack;
        next_done = 1'b0;
        next_cmd = cmd;
        if (state == vcip_pkg::I2C_IDLE) begin
            next_qcnt = vcip_pkg::QCNT_RST;
            next_phase = vcip_pkg::PHASE_RST;
            next_scl = vcip_pkg::SCL_IDLE;
            next_sda_low = 1'b0;
            if (i2c_start_i) begin
                next_cmd = i2c_cmd_i;
                next_nack = 1'b0;
                next_byten = vcip_pkg::BYTE_FIRST;
                next_state = vcip_pkg::I2C_START;
            end
        end else if (qcnt != vcip_pkg::QCNT_MAX) begin
            next_qcnt = qcnt + 6'h01;
        end else begin
            next_qcnt = vcip_pkg::QCNT_RST;
            next_phase = phase + 2'h1;
            unique case (state)
                vcip_pkg::I2C_START: begin
                    // data falls while clock is high
                    case (phase)
                        2'h0: next_sda_low = 1'b0;
                        2'h1: next_sda_low = 1'b1;
                        2'h2: next_scl = 1'b0;
                        2'h3: begin
                            next_shreg = {cmd.dev_addr, vcip_pkg::I2C_RW_WRITE};
                            next_bitn = vcip_pkg::BIT_TOP;
                            next_state = vcip_pkg::I2C_DATA;
                        end
                    endcase
                end
                vcip_pkg::I2C_DATA: begin
                    // data changes only while clock is low
                    case (phase)
                        2'h0: next_sda_low = ~shreg[7];
                        2'h1: next_scl = 1'b1;
                        2'h2: next_scl = 1'b1;
                        2'h3: begin
                            next_scl = 1'b0;
                            next_shreg = {shreg[6:0], 1'b0};
                            next_bitn = bitn - 3'h1;
                            if (bitn == vcip_pkg::BIT_LAST) begin
                                next_state = vcip_pkg::I2C_ACK;
                            end
                        end
                    endcase
                end
                vcip_pkg::I2C_ACK: begin
                    // release data so the decoder can answer
                    case (phase)
                        2'h0: next_sda_low = 1'b0;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_nack = nack | sda_sync;
                        2'h3: begin
                            next_scl = 1'b0;
                            if (next_nack || byten == vcip_pkg::BYTE_LAST) begin
                                next_state = vcip_pkg::I2C_STOP;
                            end else begin
                                next_shreg = load_byte;
                                next_byten = byten + 2'h1;
                                next_bitn = vcip_pkg::BIT_TOP;
                                next_state = vcip_pkg::I2C_DATA;
                            end
                        end
                    endcase
                end
                vcip_pkg::I2C_STOP: begin
                    // data rises while clock is high
                    case (phase)
                        2'h0: next_sda_low = 1'b1;
                        2'h1: next_scl = 1'b1;
                        2'h2: next_sda_low = 1'b0;
                        2'h3: begin
                            next_done = 1'b1;
                            next_state = vcip_pkg::I2C_IDLE;
                        end
                    endcase
                end
                vcip_pkg::I2C_IDLE: next_state = vcip_pkg::I2C_IDLE;
            endcase
        end
        if (rst_i) begin
            next_state = vcip_pkg::I2C_IDLE;
            next_phase = vcip_pkg::PHASE_RST;
            next_qcnt = vcip_pkg::QCNT_RST;
            next_bitn = vcip_pkg::BIT_TOP;
            next_byten = vcip_pkg::BYTE_FIRST;
            next_shreg = 8'h00;
            next_scl = vcip_pkg::SCL_IDLE;
            next_sda_low = 1'b0;
            next_nack = 1'b0;
            next_done = 1'b0;
            next_cmd = '0;
        end
    end

    // controller registers
    always_ff @(posedge core_clk_i) begin
        state <= next_state;
        phase <= next_phase;
        qcnt <= next_qcnt;
        bitn <= next_bitn;
        byten <= next_byten;
        shreg <= next_shreg;
        scl <= next_scl;
        sda_low <= next_sda_low;
        nack <= next_nack;
        done <= next_done;
        cmd <= next_cmd;
    end

    // open drain data: the data pad only ever pulls low; the clock pad is driven at both levels
    assign decoder_ctrl_scl_o = scl;
    assign decoder_ctrl_sda_o = 1'b0;
    assign decoder_ctrl_sda_oe_o = sda_low;
    assign i2c_busy_o = (state != vcip_pkg::I2C_IDLE);
    assign i2c_done_o = done;
    assign i2c_nack_o = nack;
endmodule : vcip_capture_port
`default_nettype wire

/* File: vcip_checker.sv */
// assertion checker for the video capture input port
`timescale 1ns/1ps
`default_nettype none
module vcip_checker (
    input wire logic core_clk_i, // core clock
    input wire logic rst_i, // reset, active high
    input wire logic pixel_clock_in_i, // pixel clock
    input wire logic [vcip_pkg::PIX_W-1:0] video_pixel_bus_i, // pixel bus
    input wire logic horizontal_reference_in_i, // line sync
    input wire logic vertical_sync_in_i, // field sync
    input wire logic mode_yuv_i, // yuv mode
    input wire logic mode_8bit_i, // low lane mode
    input wire vcip_pkg::vcip_pixel_t pixel_o, // captured pixel
    input wire logic field_start_o, // field pulse
    input wire logic i2c_start_i, // write request
    input wire logic i2c_busy_o, // transfer running
    input wire logic i2c_done_o, // transfer finished
    input wire logic decoder_ctrl_scl_o, // serial clock
    input wire logic decoder_ctrl_sda_oe_o // data pull enable
);
    logic [7:0] low_cnt; // length of the current serial clock low run
    logic [7:0] next_low_cnt; // next run length
    // run length counter, cleared whenever the clock is high
    always_comb begin
        next_low_cnt = decoder_ctrl_scl_o ? 8'h00 : low_cnt + 8'h01;
    end
    always_ff @(posedge core_clk_i) begin
        low_cnt <= rst_i ? 8'h00 : next_low_cnt;
    end
    // accepted write request
    sequence start_req;
        i2c_start_i && !i2c_busy_o;
    endsequence
    // start condition: data pulled while the clock is high
    sequence start_cond;
        decoder_ctrl_sda_oe_o && decoder_ctrl_scl_o;
    endsequence
    // pipeline is three pixel edges; mode must have settled first
    line_edge_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        $changed(horizontal_reference_in_i) |-> ##3 pixel_o.line_start)
        else $error("line start missing after reference edge");
    field_edge_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        $changed(vertical_sync_in_i) |-> ##3 pixel_o.field_start)
        else $error("field start missing after vertical edge");
    field_parity_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        $changed(vertical_sync_in_i) |-> ##3 pixel_o.field_odd == $past(horizontal_reference_in_i, 3))
        else $error("field parity differs from reference level");
    rgb_lanes_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        !mode_yuv_i && !$past(mode_yuv_i, 6) |-> pixel_o.blue == $past(video_pixel_bus_i[4:0], 3)
        && pixel_o.green[1:0] == $past(video_pixel_bus_i[6:5], 3))
        else $error("rgb low lanes misplaced");
    yuv_chroma_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        mode_yuv_i && $past(mode_yuv_i, 6) |-> pixel_o.chroma == $past(video_pixel_bus_i[7:0], 3)
        && pixel_o.blue == 5'h00)
        else $error("yuv chroma lanes misplaced");
    chroma_alt_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        mode_yuv_i && $past(mode_yuv_i, 6) && !pixel_o.line_start && !pixel_o.field_start
        |-> pixel_o.chroma_v != $past(pixel_o.chroma_v))
        else $error("chroma phase did not alternate");
    low_lane_a: assert property (@(posedge pixel_clock_in_i) disable iff (rst_i)
        mode_8bit_i && $past(mode_8bit_i, 6) |-> pixel_o.red == 5'h00 && pixel_o.luma == 8'h00)
        else $error("upper lanes used in low lane mode");
    field_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        field_start_o |=> !field_start_o)
        else $error("field pulse longer than one cycle");
    start_busy_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        start_req |=> i2c_busy_o ##[0:200] start_cond)
        else $error("write request not started");
    done_end_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        i2c_done_o |-> !i2c_busy_o ##1 !i2c_done_o)
        else $error("done pulse malformed");
    idle_lines_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !i2c_busy_o && !$past(i2c_busy_o) |-> decoder_ctrl_scl_o && !decoder_ctrl_sda_oe_o)
        else $error("serial lines not idle");
    scl_low_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(decoder_ctrl_scl_o) && i2c_busy_o |-> low_cnt == 8'h64 || low_cnt == 8'h96)
        else $error("serial clock low time wrong");
endmodule : vcip_checker
`default_nettype wire

/* File: vcip_decoder_model.sv */
// behavioural model of the external video decoder
`timescale 1ns/1ps
`default_nettype none
module vcip_decoder_model (
    input wire logic rst_i, // hold still while high
    input wire logic en_i, // stream runs while high
    input wire logic nack_i, // refuse acknowledges
    input wire logic want_odd_i, // reference level wanted at field edge
    input wire logic field_req_i, // toggle asks for one field edge
    output logic pclk_o, // pixel clock
    output logic [15:0] bus_o, // pixel bus
    output logic href_o, // line sync
    output logic vsync_o, // field sync
    input wire logic scl_i, // serial clock wire
    input wire logic sda_i, // serial data wire
    output logic sda_pull_o // pulls data low
);
    logic [3:0] pix_cnt = 4'h0; // pixels in the current line
    logic fld_seen = 1'b0; // last request served
    int bit_cnt = 0; // clock rises since start
    initial begin
        {bus_o, href_o, vsync_o, sda_pull_o} = '0;
        pclk_o = 1'b0;
        #3;
        forever #16 pclk_o = ~pclk_o;
    end
    // data launched just after the pixel edge, lines every twelve pixels
    always @(posedge pclk_o) begin
        #2;
        if (!rst_i && en_i) begin
            bus_o <= bus_o + 16'h1357;
            pix_cnt <= (pix_cnt == 4'hB) ? 4'h0 : pix_cnt + 4'h1;
            if (pix_cnt == 4'hB) begin
                href_o <= ~href_o;
            end
            // field edge only well away from a line edge
            if (field_req_i != fld_seen && href_o == want_odd_i && pix_cnt < 4'h8) begin
                vsync_o <= ~vsync_o;
                fld_seen <= field_req_i;
            end
        end
    end
    // start condition restarts the bit count
    always @(negedge sda_i) begin
        if (scl_i) begin
            bit_cnt = 0;
        end
    end
    always @(posedge scl_i) begin
        bit_cnt = bit_cnt + 1;
    end
    // acknowledge slot follows each eighth bit
    always @(negedge scl_i) begin
        sda_pull_o = !nack_i && (bit_cnt == 8 || bit_cnt == 17 || bit_cnt == 26);
    end
endmodule : vcip_decoder_model
`default_nettype wire

/* File: tb_video_capture_input_port.sv */
// self-checking bench for the video capture input port
`timescale 1ns/1ps
`default_nettype none
module tb_video_capture_input_port;
    logic core_clk_i = 1'b0; // core clock
    logic rst_i = 1'b1; // reset
    logic pclk, href, vsync, sda_pull, scl, sda_o, sda_oe, sda_wire; // link signals
    logic [15:0] bus; // pixel bus
    logic yuv = 1'b0, b8 = 1'b0, en = 1'b0, nack_en = 1'b0, want_odd = 1'b0, freq = 1'b0;
    logic start = 1'b0; // write request
    vcip_pkg::vcip_i2c_cmd_t cmd = '0; // write contents
    vcip_pkg::vcip_pixel_t pix; // captured pixel
    logic valid, fstart, lstart, fodd, busy, done, nack; // status outputs
    logic [27:0] cap = '0; // bits seen on the wire at clock rises
    int fails = 0, total_checks = 0, line_px = 0, line_core = 0;
    always #25 core_clk_i = ~core_clk_i;
    // open drain data with pull-up
    assign sda_wire = (sda_oe ? sda_o : 1'b1) & ~sda_pull;
    vcip_capture_port dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .pixel_clock_in_i(pclk),
        .video_pixel_bus_i(bus), .horizontal_reference_in_i(href), .vertical_sync_in_i(vsync),
        .mode_yuv_i(yuv), .mode_8bit_i(b8), .pixel_o(pix), .pixel_valid_o(valid),
        .field_start_o(fstart), .line_start_o(lstart), .field_odd_o(fodd), .i2c_start_i(start),
        .i2c_cmd_i(cmd), .i2c_busy_o(busy), .i2c_done_o(done), .i2c_nack_o(nack),
        .decoder_ctrl_scl_o(scl), .decoder_ctrl_sda_i(sda_wire), .decoder_ctrl_sda_o(sda_o),
        .decoder_ctrl_sda_oe_o(sda_oe));
    vcip_decoder_model dec_u (.rst_i(rst_i), .en_i(en), .nack_i(nack_en), .want_odd_i(want_odd),
        .field_req_i(freq), .pclk_o(pclk), .bus_o(bus), .href_o(href), .vsync_o(vsync),
        .scl_i(scl), .sda_i(sda_wire), .sda_pull_o(sda_pull));
    // wire capture and line event counters
    always @(posedge scl) if (busy) cap <= {cap[26:0], sda_wire};
    always @(negedge pclk) if (pix.line_start === 1'b1) line_px++;
    always @(negedge core_clk_i) if (lstart === 1'b1) line_core++;
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    // bounded wait on a core pulse; zero selects done, one field start
    task automatic wait_pulse(input bit sel, input int limit);
        int i;
        for (i = 0; i < limit; i++) begin
            @(negedge core_clk_i);
            if ((sel ? fstart : done) === 1'b1) return;
        end
        fails++;
        results();
    endtask : wait_pulse
    // one field edge at a chosen reference level
    task automatic field_test(input logic odd);
        want_odd = odd;
        freq = ~freq;
        wait_pulse(1'b1, 400);
        repeat (3) @(negedge core_clk_i);
        check_val("field_odd", {31'h0, odd}, {31'h0, fodd});
        check_val("pixel_valid", 32'h1, {31'h0, valid});
    endtask : field_test
    // exactly twenty reference edges in a 240 pixel window
    task automatic line_test();
        int a, b;
        en = 1'b0;
        repeat (20) @(negedge core_clk_i);
        a = line_px;
        b = line_core;
        // window in whole pixel steps, so it holds exactly 240 pixels
        @(negedge pclk);
        en = 1'b1;
        repeat (240) @(negedge pclk);
        en = 1'b0;
        repeat (20) @(negedge core_clk_i);
        check_val("pixel_lines", 32'd20, line_px - a);
        check_val("core_lines", 32'd20, line_core - b);
        en = 1'b1;
    endtask : line_test
    // lane layout in each colour and width mode
    task automatic mode_test(input logic y, input logic n8);
        yuv = y;
        b8 = n8;
        repeat (20) @(negedge pclk);
        if (y) begin
            check_val("rgb_in_yuv", 32'h0, {16'h0, pix.red, pix.green, pix.blue});
        end else begin
            check_val("yuv_in_rgb", 32'h0, {16'h0, pix.luma, pix.chroma});
        end
        if (n8) begin
            check_val("upper_lanes", 32'h0, {19'h0, pix.red, pix.luma});
        end
    endtask : mode_test
    // register write, with a refused request in mid-transfer
    task automatic i2c_test(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d,
                            input logic refuse);
        @(negedge core_clk_i);
        nack_en = refuse;
        cmd = '{dev_addr: dev, reg_addr: ra, data: d};
        start = 1'b1;
        @(negedge core_clk_i);
        start = 1'b0;
        repeat (300) @(negedge core_clk_i);
        cmd = '{dev_addr: 7'h7F, reg_addr: 8'hFF, data: 8'hFF};
        start = 1'b1;
        @(negedge core_clk_i);
        start = 1'b0;
        wait_pulse(1'b0, 8000);
        @(negedge core_clk_i);
        check_val("busy_after", 32'h0, {31'h0, busy});
        check_val("nack", {31'h0, refuse}, {31'h0, nack});
        if (refuse) begin
            check_val("wire_bits", {22'h0, dev, 3'h2}, {22'h0, cap[9:0]});
        end else begin
            check_val("wire_bits", {4'h0, dev, 2'h0, ra, 1'b0, d, 2'h0}, {4'h0, cap});
        end
        nack_en = 1'b0;
    endtask : i2c_test
    initial begin
        repeat (2) @(negedge core_clk_i);
        rst_i = 1'b0;
        check_val("idle_scl", 32'h1, {31'h0, scl});
        check_val("idle_pull", 32'h0, {31'h0, sda_oe});
        repeat (10) @(negedge core_clk_i);
        check_val("valid_before", 32'h0, {31'h0, valid});
        en = 1'b1;
        field_test(1'b1);
        field_test(1'b0);
        line_test();
        for (int m = 0; m < 4; m++) mode_test(m[0], m[1]);
        i2c_test(7'h2A, 8'h5C, 8'hC3, 1'b0);
        i2c_test(7'h55, 8'hA1, 8'h3E, 1'b0);
        i2c_test(7'h13, 8'h00, 8'h81, 1'b1);
        results();
    end
endmodule : tb_video_capture_input_port
bind vcip_capture_port vcip_checker chk_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .pixel_clock_in_i(pixel_clock_in_i), .video_pixel_bus_i(video_pixel_bus_i),
    .horizontal_reference_in_i(horizontal_reference_in_i),
    .vertical_sync_in_i(vertical_sync_in_i), .mode_yuv_i(mode_yuv_i),
    .mode_8bit_i(mode_8bit_i), .pixel_o(pixel_o), .field_start_o(field_start_o),
    .i2c_start_i(i2c_start_i), .i2c_busy_o(i2c_busy_o), .i2c_done_o(i2c_done_o),
    .decoder_ctrl_scl_o(decoder_ctrl_scl_o), .decoder_ctrl_sda_oe_o(decoder_ctrl_sda_oe_o));
`default_nettype wire
